// File: rtl/bya_pkg.sv
// Shared constants and types for the byte ALU instruction subset block.
// Assumes a single APB clock domain and 32-bit APB data.
package bya_pkg;

    // Register byte offsets on the APB bus.
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_INSTR = 8'h00;
    localparam logic [7:0] OFS_ACC = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_PTR0 = 8'h0C;
    localparam logic [7:0] OFS_PTR1 = 8'h10;
    localparam logic [7:0] OFS_DIR_A = 8'h14;
    localparam logic [7:0] OFS_DIR_B = 8'h18;
    localparam logic [7:0] OFS_DIR_C = 8'h1C;
    localparam logic [7:0] OFS_FILE_ADDR = 8'h20;
    localparam logic [7:0] OFS_FILE_DATA = 8'h24;

    // Instruction word layout.
    localparam int INSTR_OPND_LSB = 0;
    localparam int INSTR_OP_LSB = 16;
    localparam int INSTR_OP_W = 4;
    localparam int INSTR_DEST_BIT = 20;
    localparam int INSTR_PSEL_BIT = 21;

    // Status flag positions.
    localparam int FLAG_CARRY = 0;
    localparam int FLAG_DIGIT = 1;
    localparam int FLAG_ZERO = 2;

    // Operand codes that pick a port direction register.
    localparam logic [7:0] DIR_CODE_A = 8'h05;
    localparam logic [7:0] DIR_CODE_B = 8'h06;
    localparam logic [7:0] DIR_CODE_C = 8'h07;

    localparam int FILE_AW = 7;
    localparam int PTR_K_W = 6;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [15:0] PTR_RST = 16'h0000;
    localparam logic [7:0] DIR_RST = 8'hFF;

    typedef enum logic [INSTR_OP_W-1:0] {
        OP_PTR_ADD,
        OP_AND_LIT,
        OP_ADD_LIT,
        OP_AND_FILE,
        OP_ADD_FILE,
        OP_ASR_FILE,
        OP_ADDC_FILE,
        OP_LOAD_DIR,
        OP_XOR_LIT,
        OP_XOR_FILE
    } bya_op_t;

endpackage

// File: rtl/bya_alu_if.sv
// Carrier between the register shell and the combinational ALU.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ns
`default_nettype none
interface bya_alu_if import bya_pkg::*; ();
    bya_op_t op;
    logic dest;
    logic [7:0] operand;
    logic [7:0] acc;
    logic [7:0] file_val;
    logic carry_in;
    logic [15:0] ptr_in;
    logic [7:0] result;
    logic [15:0] ptr_out;
    logic carry_out;
    logic digit_out;
    logic zero_out;
    logic upd_carry;
    logic upd_digit;
    logic upd_zero;
    logic wr_acc;
    logic wr_file;
    logic wr_dir;
    logic wr_ptr;
    logic op_ok;

    modport alu (
        input op, dest, operand, acc, file_val, carry_in, ptr_in,
        output result, ptr_out, carry_out, digit_out, zero_out,
        output upd_carry, upd_digit, upd_zero,
        output wr_acc, wr_file, wr_dir, wr_ptr, op_ok
    );
    modport user (
        output op, dest, operand, acc, file_val, carry_in, ptr_in,
        input result, ptr_out, carry_out, digit_out, zero_out,
        input upd_carry, upd_digit, upd_zero,
        input wr_acc, wr_file, wr_dir, wr_ptr, op_ok
    );
endinterface
`default_nettype wire

// File: rtl/bya_alu.sv
// Combinational ALU for the byte instruction subset.
// Assumes the shell applies results only on its own execute strobe.
`timescale 1ns/1ns
`default_nettype none
module bya_alu import bya_pkg::*; (
    bya_alu_if.alu bus
);
    // Returns {digit carry, carry, sum}.
    function automatic logic [9:0] add_bytes(
        input logic [7:0] a,
        input logic [7:0] b,
        input logic cin
    );
        logic [8:0] full;
        logic [4:0] low;
        full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        return {low[4], full};
    endfunction

    logic [7:0] src_w;
    logic [9:0] sum_w;
    logic [15:0] k_ext_w;
    logic is_file_w;

    assign is_file_w = (bus.op == OP_AND_FILE) || (bus.op == OP_ADD_FILE)
        || (bus.op == OP_ASR_FILE) || (bus.op == OP_ADDC_FILE)
        || (bus.op == OP_XOR_FILE);
    assign src_w = is_file_w ? bus.file_val : bus.operand;
    assign sum_w = add_bytes(bus.acc, src_w,
        (bus.op == OP_ADDC_FILE) & bus.carry_in);
    // The 16-bit sum drops its carry, so the pointer wraps both ways.
    assign k_ext_w = {{(16-PTR_K_W){bus.operand[PTR_K_W-1]}},
        bus.operand[PTR_K_W-1:0]};
    assign bus.ptr_out = bus.ptr_in + k_ext_w;
    assign bus.zero_out = (bus.result == 8'h00);
    assign bus.wr_file = is_file_w & bus.dest;
    assign bus.wr_acc = bus.op_ok & ~bus.wr_file & ~bus.wr_ptr & ~bus.wr_dir;

    always_comb
    begin
        bus.result = 8'h00;
        bus.carry_out = 1'b0;
        bus.digit_out = 1'b0;
        bus.upd_carry = 1'b0;
        bus.upd_digit = 1'b0;
        bus.upd_zero = 1'b0;
        bus.wr_dir = 1'b0;
        bus.wr_ptr = 1'b0;
        bus.op_ok = 1'b1;
        case (bus.op)
            OP_PTR_ADD:
                bus.wr_ptr = 1'b1;
            OP_AND_LIT, OP_AND_FILE:
            begin
                bus.result = bus.acc & src_w;
                bus.upd_zero = 1'b1;
            end
            OP_XOR_LIT, OP_XOR_FILE:
            begin
                bus.result = bus.acc ^ src_w;
                bus.upd_zero = 1'b1;
            end
            OP_ADD_LIT, OP_ADD_FILE, OP_ADDC_FILE:
            begin
                bus.result = sum_w[7:0];
                bus.carry_out = sum_w[8];
                bus.digit_out = sum_w[9];
                bus.upd_carry = 1'b1;
                bus.upd_digit = 1'b1;
                bus.upd_zero = 1'b1;
            end
            OP_ASR_FILE:
            begin
                bus.result = {bus.file_val[7], bus.file_val[7:1]};
                bus.carry_out = bus.file_val[0];
                bus.upd_carry = 1'b1;
                bus.upd_zero = 1'b1;
            end
            OP_LOAD_DIR:
            begin
                bus.wr_dir = 1'b1;
                bus.op_ok = (bus.operand == DIR_CODE_A)
                    || (bus.operand == DIR_CODE_B)
                    || (bus.operand == DIR_CODE_C);
            end
            default:
                bus.op_ok = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// File: rtl/bya_top.sv
// Register shell and APB slave for the byte ALU instruction subset.
// Assumes an APB master on pclk; the data file lives in this block.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - pointer add takes a signed 6-bit literal, selected pair, flags untouched.
// - the 16-bit pointer wraps modulo 65536, never saturates.
// - AND literal writes the accumulator and updates only zero.
// - add literal writes the accumulator, updates carry, digit carry, zero.
// - AND with file goes to accumulator or location by dest; zero only.
// - add with file goes to chosen destination; carry, digit carry, zero.
// - shift right keeps bit 7, bit 0 into carry; carry and zero.
// - add with carry sums accumulator, location, carry; all three flags.
// - load direction copies accumulator to port A, B, C for 5, 6, 7.
// - XOR literal writes the accumulator and updates only zero.
// - XOR with file goes to accumulator or location by dest; zero only.
module bya_top import bya_pkg::*; #(
    parameter int FILE_DEPTH = 128
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [7:0] port_a_dir,
    output logic [7:0] port_b_dir,
    output logic [7:0] port_c_dir
);
    bya_alu_if alu_bus ();

    bya_alu u_alu (
        .bus(alu_bus)
    );

    logic [7:0] file_mem [FILE_DEPTH];

    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic [7:0] acc_reg;
    logic [7:0] acc_next;
    logic carry_reg;
    logic carry_next;
    logic digit_reg;
    logic digit_next;
    logic zero_reg;
    logic zero_next;
    logic [15:0] ptr0_reg;
    logic [15:0] ptr0_next;
    logic [15:0] ptr1_reg;
    logic [15:0] ptr1_next;
    logic [7:0] dir_a_reg;
    logic [7:0] dir_a_next;
    logic [7:0] dir_b_reg;
    logic [7:0] dir_b_next;
    logic [7:0] dir_c_reg;
    logic [7:0] dir_c_next;
    logic [FILE_AW-1:0] faddr_reg;
    logic [FILE_AW-1:0] faddr_next;

    // Address decode.
    wire hit_instr = (paddr == OFS_INSTR);
    wire hit_acc = (paddr == OFS_ACC);
    wire hit_status = (paddr == OFS_STATUS);
    wire hit_ptr0 = (paddr == OFS_PTR0);
    wire hit_ptr1 = (paddr == OFS_PTR1);
    wire hit_dir_a = (paddr == OFS_DIR_A);
    wire hit_dir_b = (paddr == OFS_DIR_B);
    wire hit_dir_c = (paddr == OFS_DIR_C);
    wire hit_faddr = (paddr == OFS_FILE_ADDR);
    wire hit_fdata = (paddr == OFS_FILE_DATA);
    wire addr_ok = hit_instr | hit_acc | hit_status | hit_ptr0 | hit_ptr1
        | hit_dir_a | hit_dir_b | hit_dir_c | hit_faddr | hit_fdata;

    // One wait state: pready rises on the edge after the first access cycle and the
    // transfer takes effect on the edge that samples it high.
    wire access_first = psel & penable & ~pready_reg;
    wire commit = psel & penable & pready_reg;
    wire bad_instr = pwrite & hit_instr & ~alu_bus.op_ok;
    wire err_w = ~addr_ok | bad_instr;
    wire wr_ok = commit & pwrite & ~err_w;
    wire exec_w = wr_ok & hit_instr;

    // Instruction fields come straight from the held write data.
    wire [7:0] opnd_w = pwdata[INSTR_OPND_LSB +: 8];
    wire [FILE_AW-1:0] fsel_w = opnd_w[FILE_AW-1:0];
    wire ptr_sel_w = pwdata[INSTR_PSEL_BIT];

    assign alu_bus.op = bya_op_t'(pwdata[INSTR_OP_LSB +: INSTR_OP_W]);
    assign alu_bus.dest = pwdata[INSTR_DEST_BIT];
    assign alu_bus.operand = opnd_w;
    assign alu_bus.acc = acc_reg;
    assign alu_bus.file_val = file_mem[fsel_w];
    assign alu_bus.carry_in = carry_reg;
    assign alu_bus.ptr_in = ptr_sel_w ? ptr1_reg : ptr0_reg;

    wire alu_acc = exec_w & alu_bus.wr_acc;
    wire alu_file = exec_w & alu_bus.wr_file;
    wire alu_ptr = exec_w & alu_bus.wr_ptr;
    wire alu_dir = exec_w & alu_bus.wr_dir;

    assign acc_next = alu_acc ? alu_bus.result
        : (wr_ok & hit_acc) ? pwdata[7:0] : acc_reg;
    // Flags move only when the operation names them or on a status register write.
    assign carry_next = (exec_w & alu_bus.upd_carry) ? alu_bus.carry_out
        : (wr_ok & hit_status) ? pwdata[FLAG_CARRY] : carry_reg;
    assign digit_next = (exec_w & alu_bus.upd_digit) ? alu_bus.digit_out
        : (wr_ok & hit_status) ? pwdata[FLAG_DIGIT] : digit_reg;
    assign zero_next = (exec_w & alu_bus.upd_zero) ? alu_bus.zero_out
        : (wr_ok & hit_status) ? pwdata[FLAG_ZERO] : zero_reg;
    assign ptr0_next = (alu_ptr & ~ptr_sel_w) ? alu_bus.ptr_out
        : (wr_ok & hit_ptr0) ? pwdata[15:0] : ptr0_reg;
    assign ptr1_next = (alu_ptr & ptr_sel_w) ? alu_bus.ptr_out
        : (wr_ok & hit_ptr1) ? pwdata[15:0] : ptr1_reg;
    assign dir_a_next = (alu_dir & (opnd_w == DIR_CODE_A)) ? acc_reg
        : (wr_ok & hit_dir_a) ? pwdata[7:0] : dir_a_reg;
    assign dir_b_next = (alu_dir & (opnd_w == DIR_CODE_B)) ? acc_reg
        : (wr_ok & hit_dir_b) ? pwdata[7:0] : dir_b_reg;
    assign dir_c_next = (alu_dir & (opnd_w == DIR_CODE_C)) ? acc_reg
        : (wr_ok & hit_dir_c) ? pwdata[7:0] : dir_c_reg;
    assign faddr_next = (wr_ok & hit_faddr) ? pwdata[FILE_AW-1:0]
        : faddr_reg;

    wire [31:0] rdata_w =
        hit_acc ? {24'h000000, acc_reg}
        : hit_status ? {29'h00000000, zero_reg, digit_reg, carry_reg}
        : hit_ptr0 ? {16'h0000, ptr0_reg}
        : hit_ptr1 ? {16'h0000, ptr1_reg}
        : hit_dir_a ? {24'h000000, dir_a_reg}
        : hit_dir_b ? {24'h000000, dir_b_reg}
        : hit_dir_c ? {24'h000000, dir_c_reg}
        : hit_faddr ? {25'h0000000, faddr_reg}
        : hit_fdata ? {24'h000000, file_mem[faddr_reg]}
        : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end
        else
        begin
            pready_reg <= access_first;
            pslverr_reg <= access_first & err_w;
            prdata_reg <= (access_first & ~pwrite) ? rdata_w : 32'h00000000;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc_reg <= ACC_RST;
            carry_reg <= 1'b0;
            digit_reg <= 1'b0;
            zero_reg <= 1'b0;
            ptr0_reg <= PTR_RST;
            ptr1_reg <= PTR_RST;
        end
        else
        begin
            acc_reg <= acc_next;
            carry_reg <= carry_next;
            digit_reg <= digit_next;
            zero_reg <= zero_next;
            ptr0_reg <= ptr0_next;
            ptr1_reg <= ptr1_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dir_a_reg <= DIR_RST;
            dir_b_reg <= DIR_RST;
            dir_c_reg <= DIR_RST;
            faddr_reg <= '0;
        end
        else
        begin
            dir_a_reg <= dir_a_next;
            dir_b_reg <= dir_b_next;
            dir_c_reg <= dir_c_next;
            faddr_reg <= faddr_next;
        end
    end

    // The data file is not reset, as real data memory powers up unknown.
    always_ff @(posedge pclk)
    begin
        if (alu_file)
            file_mem[fsel_w] <= alu_bus.result;
        else if (wr_ok & hit_fdata)
            file_mem[faddr_reg] <= pwdata[7:0];
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign port_a_dir = dir_a_reg;
    assign port_b_dir = dir_b_reg;
    assign port_c_dir = dir_c_reg;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    wire is_op_ptr = exec_w && (alu_bus.op == OP_PTR_ADD);

    a_ptr_add_sum: assert property (
        is_op_ptr && !ptr_sel_w |=> ptr0_reg == $past(ptr0_reg)
            + {{10{$past(pwdata[5])}}, $past(pwdata[5:0])}
            && $stable({carry_reg, digit_reg, zero_reg}))
        else $error("pointer add result or flags wrong");

    a_ptr_wrap_top: assert property (
        is_op_ptr && ptr_sel_w && ptr1_reg == 16'hFFFF
            && pwdata[5:0] == 6'h01 |=> ptr1_reg == 16'h0000)
        else $error("pointer did not wrap to zero");

    a_and_lit_zero: assert property (
        exec_w && alu_bus.op == OP_AND_LIT |=>
            acc_reg == ($past(acc_reg) & $past(pwdata[7:0]))
            && zero_reg == (acc_reg == 8'h00) && $stable(carry_reg))
        else $error("AND literal wrong");

    a_add_lit_flags: assert property (
        exec_w && alu_bus.op == OP_ADD_LIT |=>
            {carry_reg, acc_reg} ==
            {1'b0, $past(acc_reg)} + {1'b0, $past(pwdata[7:0])})
        else $error("add literal sum or carry wrong");

    a_file_dest_sel: assert property (
        exec_w && alu_bus.wr_file |=> $stable(acc_reg)
            && file_mem[$past(fsel_w)] == $past(alu_bus.result))
        else $error("file destination not honoured");

    a_add_file_acc: assert property (
        exec_w && alu_bus.op == OP_ADD_FILE && !alu_bus.dest |=>
            {carry_reg, acc_reg} == {1'b0, $past(acc_reg)}
            + {1'b0, $past(alu_bus.file_val)})
        else $error("add with file wrong");

    a_asr_shift: assert property (
        exec_w && alu_bus.op == OP_ASR_FILE && !alu_bus.dest |=>
            acc_reg[7] == acc_reg[6] && carry_reg == $past(alu_bus.file_val[0]))
        else $error("shift right lost sign or carry");

    a_addc_sum: assert property (
        exec_w && alu_bus.op == OP_ADDC_FILE && !alu_bus.dest |=>
            {carry_reg, acc_reg} == {1'b0, $past(acc_reg)}
            + {1'b0, $past(alu_bus.file_val)} + {8'h00, $past(carry_reg)})
        else $error("add with carry wrong");

    a_dir_load_b: assert property (
        exec_w && alu_bus.op == OP_LOAD_DIR && opnd_w == DIR_CODE_B |=>
            port_b_dir == $past(acc_reg) && $stable(port_a_dir)
            && $stable({carry_reg, digit_reg, zero_reg}))
        else $error("direction load wrong");

    a_xor_lit_acc: assert property (
        exec_w && alu_bus.op == OP_XOR_LIT |=>
            acc_reg == ($past(acc_reg) ^ $past(pwdata[7:0]))
            && $stable(digit_reg))
        else $error("XOR literal wrong");

    a_xor_file_zero: assert property (
        exec_w && alu_bus.op == OP_XOR_FILE && !alu_bus.dest |=>
            zero_reg == (($past(acc_reg) ^ $past(alu_bus.file_val)) == 8'h00))
        else $error("XOR with file zero flag wrong");

    a_digit_carry: assert property (
        exec_w && alu_bus.op == OP_ADD_LIT |=> digit_reg ==
            (({1'b0, $past(acc_reg[3:0])} + {1'b0, $past(pwdata[3:0])})
            > 5'h0F))
        else $error("digit carry wrong");

    a_ready_pulse: assert property (
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("pready not a single cycle pulse");

    c_add_carry: cover property (
        exec_w && alu_bus.op == OP_ADD_FILE ##1 carry_reg);
    c_ptr_wrap: cover property (is_op_ptr && ptr0_reg == 16'h0000
        && !ptr_sel_w && pwdata[5]);
    c_bad_access: cover property (pslverr);
    c_dir_load: cover property (exec_w && alu_bus.wr_dir);
endmodule
`default_nettype wire

// File: test/bya_apb_master.sv
// APB master standing in for the instruction decoder side of the core.
// Assumes one pclk domain; the bench calls xfer for every transfer.
`timescale 1ns/1ns
`default_nettype none
module bya_apb_master import bya_pkg::*; (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [ADDR_W-1:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end

    // The wait has no cap of its own; a dead slave is caught by the bench
    // timeout, which then reports it.
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                        input logic [31:0] d, output logic [31:0] r,
                        output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released address and write-data lines show the inverse so stale values cannot pass.
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule
`default_nettype wire

// File: test/byte_alu_instruction_subset_tb.sv
// Self-checking bench for the byte ALU register shell.
// Assumes bya_top on APB and the master model in bya_apb_master.
`timescale 1ns/1ns
`default_nettype none
`define chk(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin \
    bad_count++; $display("Error %s expected %h seen %h", nm, exp, got); \
    end end
module byte_alu_instruction_subset_tb import bya_pkg::*;;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    wire logic psel, penable, pwrite, pready, pslverr;
    wire logic [ADDR_W-1:0] paddr;
    wire logic [31:0] pwdata, prdata;
    wire logic [7:0] port_a_dir, port_b_dir, port_c_dir;
    int bad_count = 0;
    int num_checks = 0;
    int cyc = 0;
    logic [7:0] da[3] = '{8'h9C, 8'h80, 8'h08};
    logic [7:0] df[3] = '{8'h63, 8'h80, 8'h08};
    logic [2:0] ds[3] = '{3'b011, 3'b100, 3'b000};

    always #2 pclk = ~pclk;

    bya_apb_master mst_u (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    bya_top #(.FILE_DEPTH(128)) dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port_a_dir(port_a_dir),
        .port_b_dir(port_b_dir), .port_c_dir(port_c_dir));

    task automatic results();
        if (bad_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            results();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        mst_u.xfer(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a,
                          input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        mst_u.xfer(1'b0, a, 32'h0000_0000, r, e);
        `chk(nm, exp, r)
    endtask

    task automatic ex(input logic [3:0] op, input logic d, input logic p,
                      input logic [7:0] opnd, output logic e);
        logic [31:0] w;
        logic [31:0] r;
        w = 32'h0000_0000;
        w[INSTR_OPND_LSB +: 8] = opnd;
        w[INSTR_OP_LSB +: INSTR_OP_W] = op;
        w[INSTR_DEST_BIT] = d;
        w[INSTR_PSEL_BIT] = p;
        mst_u.xfer(1'b1, OFS_INSTR, w, r, e);
    endtask

    // Returns flags in [10:8] and the 8-bit result in [7:0].
    function automatic logic [10:0] ref_op(input logic [3:0] op,
        input logic [7:0] a, input logic [7:0] f, input logic [2:0] st);
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] r;
        logic [2:0] o;
        logic cin;
        o = st;
        cin = (op == OP_ADDC_FILE) ? st[FLAG_CARRY] : 1'b0;
        case (op)
            OP_AND_LIT, OP_AND_FILE: r = a & f;
            OP_XOR_LIT, OP_XOR_FILE: r = a ^ f;
            OP_ASR_FILE:
            begin
                r = {f[7], f[7:1]};
                o[FLAG_CARRY] = f[0];
            end
            default:
            begin
                s = a + f + cin;
                h = a[3:0] + f[3:0] + cin;
                r = s[7:0];
                o[FLAG_CARRY] = s[8];
                o[FLAG_DIGIT] = h[4];
            end
        endcase
        o[FLAG_ZERO] = (r == 8'h00);
        return {o, r};
    endfunction

    task automatic t_reset();
        rd_chk("acc reset", OFS_ACC, {24'h0, ACC_RST});
        rd_chk("status reset", OFS_STATUS, 32'h0000_0000);
        rd_chk("ptr0 reset", OFS_PTR0, {16'h0, PTR_RST});
    endtask

    task automatic t_lit();
        logic [3:0] ops[3] = '{OP_AND_LIT, OP_ADD_LIT, OP_XOR_LIT};
        logic [10:0] x;
        logic e;
        for (int i = 0; i < 3; i++)
            for (int j = 0; j < 3; j++)
            begin
                wr(OFS_ACC, {24'h0, da[i]});
                wr(OFS_STATUS, {29'h0, ds[i]});
                ex(ops[j], 1'b0, 1'b0, df[i], e);
                x = ref_op(ops[j], da[i], df[i], ds[i]);
                rd_chk("lit acc", OFS_ACC, {24'h0, x[7:0]});
                rd_chk("lit flags", OFS_STATUS, {29'h0, x[10:8]});
            end
    endtask

    task automatic t_file();
        logic [3:0] ops[5] = '{OP_AND_FILE, OP_ADD_FILE, OP_ASR_FILE,
                               OP_ADDC_FILE, OP_XOR_FILE};
        logic [10:0] x;
        logic [7:0] fa;
        logic e;
        for (int i = 0; i < 3; i++)
            for (int j = 0; j < 5; j++)
                for (int d = 0; d < 2; d++)
                begin
                    fa = (i == 1) ? 8'h00 : 8'h7F;
                    wr(OFS_FILE_ADDR, {24'h0, fa});
                    wr(OFS_FILE_DATA, {24'h0, df[i]});
                    wr(OFS_ACC, {24'h0, da[i]});
                    wr(OFS_STATUS, {29'h0, ds[i]});
                    ex(ops[j], d[0], 1'b0, fa, e);
                    x = ref_op(ops[j], da[i], df[i], ds[i]);
                    rd_chk("file acc", OFS_ACC, {24'h0, d[0] ? da[i] : x[7:0]});
                    rd_chk("file data", OFS_FILE_DATA, {24'h0, d[0] ? x[7:0] : df[i]});
                    rd_chk("file flags", OFS_STATUS, {29'h0, x[10:8]});
                end
    endtask

    task automatic t_ptr();
        logic pp[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
        logic [15:0] ps[4] = '{16'hFFFE, 16'h0001, 16'h0001, 16'hFFFF};
        logic [5:0] pk[4] = '{6'h03, 6'h20, 6'h1F, 6'h01};
        logic [15:0] pe[4] = '{16'h0001, 16'hFFE1, 16'h0020, 16'h0000};
        logic e;
        for (int i = 0; i < 4; i++)
        begin
            wr(pp[i] ? OFS_PTR1 : OFS_PTR0, {16'h0, ps[i]});
            wr(pp[i] ? OFS_PTR0 : OFS_PTR1, 32'h0000_A55A);
            wr(OFS_STATUS, 32'h0000_0005);
            ex(OP_PTR_ADD, 1'b0, pp[i], {2'b00, pk[i]}, e);
            rd_chk("ptr sum", pp[i] ? OFS_PTR1 : OFS_PTR0, {16'h0, pe[i]});
            rd_chk("ptr other", pp[i] ? OFS_PTR0 : OFS_PTR1, 32'h0000_A55A);
            rd_chk("ptr flags", OFS_STATUS, 32'h0000_0005);
        end
    endtask

    task automatic t_dir();
        logic [7:0] v[3] = '{8'h3C, 8'hA5, 8'h5A};
        logic e;
        for (int i = 0; i < 3; i++)
        begin
            wr(OFS_ACC, {24'h0, v[i]});
            wr(OFS_STATUS, 32'h0000_0002);
            ex(OP_LOAD_DIR, 1'b0, 1'b0, DIR_CODE_A + 8'(i), e);
            // The direction outputs move on the commit edge, so look later.
            @(posedge pclk);
            `chk("dir a", v[0], port_a_dir)
            `chk("dir b", (i > 0) ? v[1] : DIR_RST, port_b_dir)
            `chk("dir c", (i > 1) ? v[2] : DIR_RST, port_c_dir)
            rd_chk("dir flags", OFS_STATUS, 32'h0000_0002);
        end
    endtask

    task automatic t_refuse();
        logic [31:0] r;
        logic e;
        wr(OFS_ACC, 32'h0000_0011);
        ex(OP_LOAD_DIR, 1'b0, 1'b0, 8'h04, e);
        @(posedge pclk);
        `chk("dir code 4 refused", 1'b1, e)
        `chk("dir a kept", 8'h3C, port_a_dir)
        ex(4'hA, 1'b0, 1'b0, 8'hFF, e);
        `chk("opcode 10 refused", 1'b1, e)
        rd_chk("acc kept", OFS_ACC, 32'h0000_0011);
        mst_u.xfer(1'b0, 8'h28, 32'h0000_0000, r, e);
        `chk("unmapped err", 1'b1, e)
        `chk("unmapped data", 32'h0000_0000, r)
    endtask

    // A reset in mid-run must clear what the earlier scenarios left behind.
    task automatic t_mid_reset();
        wr(OFS_DIR_C, 32'h0000_0012);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        `chk("dir c in reset", DIR_RST, port_c_dir)
        presetn <= 1'b1;
        @(posedge pclk);
        `chk("pready after reset", 1'b0, pready)
        rd_chk("acc after reset", OFS_ACC, {24'h0, ACC_RST});
        rd_chk("ptr1 after reset", OFS_PTR1, {16'h0, PTR_RST});
    endtask

    initial
    begin
        repeat (16) @(posedge pclk);
        `chk("dir a in reset", DIR_RST, port_a_dir)
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_lit();
        t_file();
        t_ptr();
        t_dir();
        t_refuse();
        t_mid_reset();
        results();
    end
endmodule
`default_nettype wire
